//--- rtl/ppr_cfg.svh
// Register offsets, field positions, codes and timing counts of the pin routing block
`ifndef PPR_CFG_SVH
`define PPR_CFG_SVH

// Line and selector counts
`define PPR_NLINES 16
`define PPR_NDEST 24
`define PPR_NSRC 14

// Register byte offsets
`define PPR_ADDR_CTRL 8'h00
`define PPR_ADDR_GEN_DIR 8'h04
`define PPR_ADDR_GEN_OUT 8'h08
`define PPR_ADDR_GEN_IN 8'h0C
`define PPR_ADDR_PFI_DIR 8'h10
`define PPR_ADDR_PFI_OUT 8'h14
`define PPR_ADDR_PFI_IN 8'h18
`define PPR_ADDR_PFI_MODE 8'h1C
`define PPR_ADDR_PU_GEN 8'h20
`define PPR_ADDR_PU_PFI 8'h24
`define PPR_ADDR_FILT 8'h28
`define PPR_ADDR_OSEL_LO 8'h30
`define PPR_ADDR_OSEL_HI 8'h34
`define PPR_ADDR_DEST_BASE 8'h40
`define PPR_ADDR_DEST_LAST 8'h9C

// Control register bits
`define PPR_CTRL_FIXED 0
`define PPR_CTRL_PORT_EN 1
`define PPR_CTRL_APPLY 2

// Destination register fields
`define PPR_DEST_INV 4
`define PPR_DEST_EDGE 5

// Filter setting codes
`define PPR_FILT_OFF 2'h0
`define PPR_FILT_SHORT 2'h1
`define PPR_FILT_MID 2'h2
`define PPR_FILT_LONG 2'h3

// Power-up state codes
`define PPR_PU_HIZ 2'h0
`define PPR_PU_DRIVE0 2'h1
`define PPR_PU_DRIVE1 2'h2

// Exported sources shown active low
`define PPR_SRC_CONV 4'h0
`define PPR_SRC_OUT_UPD 4'h5

// Timing: clock period and filter windows in ns, cycles rounded up
`define PPR_CLK_NS 100
`define PPR_FILT_SHORT_NS 125
`define PPR_FILT_MID_NS 6425
`define PPR_FILT_LONG_NS 2560000
`define PPR_CYC(ns) (((ns) + `PPR_CLK_NS - 1) / `PPR_CLK_NS)

`endif

//--- rtl/ppr_pkg.sv
// Types shared by the pin routing block
package ppr_pkg;
    // Timing signals that can be exported to a pin (LSB is index 0)
    typedef struct packed {
        logic freq_out;
        logic ctr1_out;
        logic ctr1_gate;
        logic ctr1_src;
        logic ctr0_out;
        logic ctr0_gate;
        logic ctr0_src;
        logic output_start_trigger;
        logic output_update_clock;
        logic input_start_trigger;
        logic input_sample_clock;
        logic input_reference_trigger;
        logic input_hold_done_event;
        logic input_conversion_clock;
    } ppr_src_type;

    // Timing destinations fed from pins (LSB is index 0)
    typedef struct packed {
        logic [6:0] ctr1_in;
        logic [6:0] ctr0_in;
        logic output_pause_trigger;
        logic output_update_timebase;
        logic output_update_clock;
        logic output_start_trigger;
        logic input_sample_timebase;
        logic input_pause_trigger;
        logic input_reference_trigger;
        logic input_start_trigger;
        logic input_sample_clock;
        logic input_conversion_clock;
    } ppr_dst_type;

    // Pin group: output enable, level out
    typedef struct packed {
        logic [15:0] oe;
        logic [15:0] out;
    } ppr_pins_type;
endpackage

//--- rtl/ppr_dio.sv
// Static digital I/O and programmable function pin routing with debounce filters
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ppr_cfg.svh"
// Function
// - Sixteen general lines, each static input or output
// - Sixteen function lines: static or timing, in or out
// - Static sampling and updates only on software access
// - Reset leaves every line undriven input
// - Stored power-up state per line: hiz, 0, 1
// - Function input: static input or timing input
// - Function output: static output or timing output
// - Debounce filter on every function input
// - Any function input pin reaches any timing destination
// - Per destination polarity and edge or level
// - Any function output pin carries any exported signal
// - Conversion and update clocks exported active low
// - Per-pin direction on function lines
// - Fixed variant: inputs via first, outputs via second
// - Fixed variant: output port off, whole-port enable
// - Filter windows of 2, 65, 25600 clock cycles
module ppr_dio #(
    parameter int FILT_LONG_CYC = `PPR_CYC(`PPR_FILT_LONG_NS)
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [15:0] gen_pin_i,
    output ppr_pkg::ppr_pins_type gen_pin_o,
    input wire logic [15:0] pfi_pin_i,
    output ppr_pkg::ppr_pins_type pfi_pin_o,
    input wire ppr_pkg::ppr_src_type timing_src_i,
    output ppr_pkg::ppr_dst_type timing_dst_o
);
    import ppr_pkg::*;

    // Filter window lengths in clock cycles
    localparam int FILT_SHORT_CYC = `PPR_CYC(`PPR_FILT_SHORT_NS);
    localparam int FILT_MID_CYC = `PPR_CYC(`PPR_FILT_MID_NS);

    logic [2:0] ctrl; // Fixed mode, port enable, apply pulse
    logic [15:0] gen_dir; // 1 drives the general line
    logic [15:0] gen_out; // Static values of general lines
    logic [15:0] pfi_dir; // 1 drives the function line
    logic [15:0] pfi_out; // Static values of function lines
    logic [15:0] pfi_mode; // 1 selects timing output
    logic [31:0] pu_gen; // Power-up codes, two bits per line
    logic [31:0] pu_pfi; // Power-up codes, two bits per line
    logic [31:0] filt_cfg; // Filter code, two bits per line
    logic [63:0] osel; // Exported source, four bits per pin
    logic [5:0] dest_cfg [`PPR_NDEST]; // Pin, invert, edge per destination
    logic [15:0] gen_s1; // First synchroniser stage, general
    logic [15:0] gen_s2; // Second synchroniser stage, general
    logic [15:0] pfi_s1; // First synchroniser stage, function
    logic [15:0] pfi_s2; // Second synchroniser stage, function
    logic [15:0] pfi_filt; // Debounced function inputs
    logic [`PPR_NDEST-1:0] dst_prev; // Previous routed level
    logic [`PPR_NDEST-1:0] dst_lvl; // Routed level after polarity
    logic [15:0] exported; // Timing value per output pin
    logic [15:0] src_ext; // Sources padded so the two spare codes select zero
    logic commit; // Bus access completes this edge
    logic wr_commit; // Write completes this edge
    logic [31:0] next_readdata; // Read mux result

    // Filter window for a setting code
    function automatic logic [14:0] filt_limit(input logic [1:0] code);
        unique case (code)
            `PPR_FILT_SHORT: filt_limit = 15'(FILT_SHORT_CYC);
            `PPR_FILT_MID: filt_limit = 15'(FILT_MID_CYC);
            `PPR_FILT_LONG: filt_limit = 15'(FILT_LONG_CYC);
            default: filt_limit = 15'h0001;
        endcase
    endfunction

    // Power-up code to direction and value
    function automatic logic [1:0] pu_decode(input logic [1:0] code);
        unique case (code)
            `PPR_PU_DRIVE0: pu_decode = 2'b10;
            `PPR_PU_DRIVE1: pu_decode = 2'b11;
            default: pu_decode = 2'b00;
        endcase
    endfunction

    assign commit = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign wr_commit = commit & avs_write_i;

    // Bus handshake: one wait cycle, then completion
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            avs_waitrequest_o <= 1'b1;
        else if (commit)
            avs_waitrequest_o <= 1'b1;
        else if (avs_read_i | avs_write_i)
            avs_waitrequest_o <= 1'b0;
    end

    // Read mux; pins are sampled only when software reads them
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        unique case (avs_address_i)
            `PPR_ADDR_CTRL: next_readdata = {30'h0000_0000, ctrl[1:0]};
            `PPR_ADDR_GEN_DIR: next_readdata = {16'h0000, gen_dir};
            `PPR_ADDR_GEN_OUT: next_readdata = {16'h0000, gen_out};
            `PPR_ADDR_GEN_IN: next_readdata = ctrl[`PPR_CTRL_FIXED] ?
                {24'h00_0000, pfi_filt[7:0]} : {16'h0000, gen_s2};
            `PPR_ADDR_PFI_DIR: next_readdata = {16'h0000, pfi_dir};
            `PPR_ADDR_PFI_OUT: next_readdata = {16'h0000, pfi_out};
            `PPR_ADDR_PFI_IN: next_readdata = {16'h0000, pfi_filt};
            `PPR_ADDR_PFI_MODE: next_readdata = {16'h0000, pfi_mode};
            `PPR_ADDR_PU_GEN: next_readdata = pu_gen;
            `PPR_ADDR_PU_PFI: next_readdata = pu_pfi;
            `PPR_ADDR_FILT: next_readdata = filt_cfg;
            `PPR_ADDR_OSEL_LO: next_readdata = osel[31:0];
            `PPR_ADDR_OSEL_HI: next_readdata = osel[63:32];
            default:
            begin
                // Destination block; anything else reads zero
                if (avs_address_i >= `PPR_ADDR_DEST_BASE && avs_address_i <= `PPR_ADDR_DEST_LAST
                    && avs_address_i[1:0] == 2'h0)
                    next_readdata = {26'h000_0000,
                        dest_cfg[5'(avs_address_i[7:2] - 6'h10)]};
            end
        endcase
    end

    // Read data captured while waitrequest falls
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (avs_read_i && avs_waitrequest_o)
            avs_readdata_o <= next_readdata;
    end

    // Control and static settings; apply loads power-up states
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl <= 3'h0;
            gen_dir <= 16'h0000;
            gen_out <= 16'h0000;
            pfi_dir <= 16'h0000;
            pfi_out <= 16'h0000;
            pfi_mode <= 16'h0000;
            pu_gen <= 32'h0000_0000;
            pu_pfi <= 32'h0000_0000;
            filt_cfg <= 32'h0000_0000;
            osel <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            ctrl[`PPR_CTRL_APPLY] <= 1'b0;
            if (ctrl[`PPR_CTRL_APPLY])
            begin
                // Load the stored power-up state of every line
                for (int i = 0; i < `PPR_NLINES; i++)
                begin
                    {gen_dir[i], gen_out[i]} <= pu_decode(pu_gen[2*i +: 2]);
                    {pfi_dir[i], pfi_out[i]} <= pu_decode(pu_pfi[2*i +: 2]);
                end
            end
            else if (wr_commit)
            begin
                // Register writes take effect at completion
                unique case (avs_address_i)
                    `PPR_ADDR_CTRL: ctrl <= avs_writedata_i[2:0];
                    `PPR_ADDR_GEN_DIR: gen_dir <= avs_writedata_i[15:0];
                    `PPR_ADDR_GEN_OUT: gen_out <= avs_writedata_i[15:0];
                    `PPR_ADDR_PFI_DIR: pfi_dir <= avs_writedata_i[15:0];
                    `PPR_ADDR_PFI_OUT: pfi_out <= avs_writedata_i[15:0];
                    `PPR_ADDR_PFI_MODE: pfi_mode <= avs_writedata_i[15:0];
                    `PPR_ADDR_PU_GEN: pu_gen <= avs_writedata_i;
                    `PPR_ADDR_PU_PFI: pu_pfi <= avs_writedata_i;
                    `PPR_ADDR_FILT: filt_cfg <= avs_writedata_i;
                    `PPR_ADDR_OSEL_LO: osel[31:0] <= avs_writedata_i;
                    `PPR_ADDR_OSEL_HI: osel[63:32] <= avs_writedata_i;
                    default: ; // Destination or unmapped
                endcase
            end
        end
    end

    // Input synchronisers, two stages per pin
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            gen_s1 <= 16'h0000;
            gen_s2 <= 16'h0000;
            pfi_s1 <= 16'h0000;
            pfi_s2 <= 16'h0000;
        end
        else
        begin
            gen_s1 <= gen_pin_i;
            gen_s2 <= gen_s1;
            pfi_s1 <= pfi_pin_i;
            pfi_s2 <= pfi_s1;
        end
    end

    // Per-line debounce filters
    generate
        for (genvar g = 0; g < `PPR_NLINES; g++)
        begin : g_filt
            logic [14:0] cnt; // Cycles the input has differed
            always_ff @(posedge mclk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    cnt <= 15'h0000;
                    pfi_filt[g] <= 1'b0;
                end
                else if (filt_cfg[2*g +: 2] == `PPR_FILT_OFF)
                begin
                    cnt <= 15'h0000;
                    pfi_filt[g] <= pfi_s2[g];
                end
                else if (pfi_s2[g] == pfi_filt[g])
                    cnt <= 15'h0000; // Glitch restarts the window
                else if (cnt >= filt_limit(filt_cfg[2*g +: 2]) - 15'h0001)
                begin
                    cnt <= 15'h0000;
                    pfi_filt[g] <= pfi_s2[g];
                end
                else
                    cnt <= cnt + 15'h0001;
            end
        end
    endgenerate

    // Destination settings and routing crossbar
    generate
        for (genvar d = 0; d < `PPR_NDEST; d++)
        begin : g_dest
            assign dst_lvl[d] = pfi_filt[dest_cfg[d][3:0]] ^ dest_cfg[d][`PPR_DEST_INV];
            always_ff @(posedge mclk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    dest_cfg[d] <= 6'h00;
                else if (wr_commit && avs_address_i == 8'(`PPR_ADDR_DEST_BASE + 4 * d))
                    dest_cfg[d] <= avs_writedata_i[5:0];
            end
            always_ff @(posedge mclk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    dst_prev[d] <= 1'b0;
                    timing_dst_o[d] <= 1'b0;
                end
                else
                begin
                    dst_prev[d] <= dst_lvl[d];
                    // Edge mode gives a pulse, level mode follows
                    timing_dst_o[d] <= dest_cfg[d][`PPR_DEST_EDGE] ?
                        (dst_lvl[d] & ~dst_prev[d]) : dst_lvl[d];
                end
            end
        end
    endgenerate

    // Spare selector codes land on constant zero instead of past the source list
    assign src_ext = {2'b00, timing_src_i};

    // Exported signal per pin; two clocks leave active low
    generate
        for (genvar p = 0; p < `PPR_NLINES; p++)
        begin : g_exp
            assign exported[p] = src_ext[osel[4*p +: 4]] ^
                (osel[4*p +: 4] == `PPR_SRC_CONV || osel[4*p +: 4] == `PPR_SRC_OUT_UPD);
        end
    endgenerate

    // Pin drivers
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            gen_pin_o <= '0;
            pfi_pin_o <= '0;
        end
        else
        begin
            gen_pin_o.oe <= ctrl[`PPR_CTRL_FIXED] ? 16'h0000 : gen_dir;
            gen_pin_o.out <= gen_out;
            pfi_pin_o.out <= (pfi_mode & exported) | (~pfi_mode & pfi_out);
            if (ctrl[`PPR_CTRL_FIXED])
                pfi_pin_o.oe <= {{8{ctrl[`PPR_CTRL_PORT_EN]}}, 8'h00};
            else
                pfi_pin_o.oe <= pfi_dir;
        end
    end

    // Checks
    wait_ack_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest did not fall one cycle after request");
    port_off_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ctrl[`PPR_CTRL_FIXED] && !ctrl[`PPR_CTRL_PORT_EN] |=> pfi_pin_o.oe == 16'h0000)
        else $error("fixed output port driven while disabled");
    conv_invert_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pfi_mode[0] && osel[3:0] == `PPR_SRC_CONV
        |=> pfi_pin_o.out[0] == !$past(timing_src_i.input_conversion_clock))
        else $error("exported conversion clock not inverted");
    gen_dir_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !ctrl[`PPR_CTRL_FIXED] |=> gen_pin_o.oe == $past(gen_dir))
        else $error("general output enable differs from direction");
    short_filter_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $changed(pfi_filt[0]) && $past(filt_cfg[1:0]) == `PPR_FILT_SHORT
        |-> $past(pfi_s2[0], 1) == pfi_filt[0] && $past(pfi_s2[0], 2) == pfi_filt[0])
        else $error("short filter passed a change too early");
    sync_delay_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $past(filt_cfg[1:0]) == `PPR_FILT_OFF && $past(filt_cfg[1:0], 2) == `PPR_FILT_OFF
        |-> pfi_filt[0] == $past(pfi_pin_i[0], 3))
        else $error("unfiltered input not three cycles behind pin");
    edge_pulse_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        dest_cfg[0][`PPR_DEST_EDGE] && $past(dest_cfg[0][`PPR_DEST_EDGE]) && timing_dst_o[0]
        |=> !timing_dst_o[0])
        else $error("edge mode destination high for two cycles");
    apply_pu_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ctrl[`PPR_CTRL_APPLY] && !ctrl[`PPR_CTRL_FIXED] && pu_gen[1:0] == `PPR_PU_DRIVE1
        |-> ##2 (gen_pin_o.oe[0] && gen_pin_o.out[0]))
        else $error("power-up drive 1 not applied to line 0");
    read_cov: cover property (@(posedge mclk_i) disable iff (!nrst_i) commit && avs_read_i);
    route_cov: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(timing_dst_o[0]));
    export_cov: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        pfi_mode[0] && pfi_pin_o.oe[0]);
endmodule

//--- tb/ppr_pin_model.sv
// Pin-side model: external drivers and weak pull-downs on sixteen lines
`timescale 1ns/1ps
module ppr_pin_model (
    input wire logic [15:0] dev_out_i,
    input wire logic [15:0] dev_oe_i,
    input wire logic [15:0] ext_val_i,
    input wire logic [15:0] ext_en_i,
    output logic [15:0] level_o
);
    // Device drive, else external drive, else pull-down; a clash shows as unknown
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (dev_oe_i[i])
                level_o[i] = ext_en_i[i] ? 1'bx : dev_out_i[i];
            else
                level_o[i] = ext_en_i[i] ? ext_val_i[i] : 1'b0;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the pin routing block over its register bus
`timescale 1ns/1ps
`include "ppr_cfg.svh"
module tb_top;
    import ppr_pkg::*;
    localparam int LONG_CYC = 10; // Shortened long filter window
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] q;
    logic waitreq;
    logic [15:0] gen_lvl;
    logic [15:0] pfi_lvl;
    logic [15:0] gen_v = 16'h0000; // External drive on general lines
    logic [15:0] gen_en = 16'h0000;
    logic [15:0] pfi_v = 16'h0000; // External drive on function lines
    logic [15:0] pfi_en = 16'h0000;
    ppr_pins_type gen_o;
    ppr_pins_type pfi_o;
    ppr_src_type src = '0;
    ppr_dst_type dst;
    int fails = 0;
    int comparisons = 0;
    int win [4] = '{1, 2, 65, LONG_CYC}; // Filter windows per code
    int cnt;

    // 10 MHz clock
    always #50 mclk_i = ~mclk_i;

    ppr_dio #(.FILT_LONG_CYC(LONG_CYC)) u_dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .gen_pin_i(gen_lvl), .gen_pin_o(gen_o),
        .pfi_pin_i(pfi_lvl), .pfi_pin_o(pfi_o), .timing_src_i(src), .timing_dst_o(dst)
    );
    ppr_pin_model u_gen (.dev_out_i(gen_o.out), .dev_oe_i(gen_o.oe), .ext_val_i(gen_v),
        .ext_en_i(gen_en), .level_o(gen_lvl));
    ppr_pin_model u_pfi (.dev_out_i(pfi_o.out), .dev_oe_i(pfi_o.oe), .ext_val_i(pfi_v),
        .ext_en_i(pfi_en), .level_o(pfi_lvl));

    // Verdict and end of run
    task automatic finish_test();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= d;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (waitreq !== 1'b0)
        begin
            fails++;
            finish_test();
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // Reset for 12 cycles; every line must be undriven meanwhile
    task automatic do_reset();
        nrst_i <= 1'b0;
        src <= '0;
        pfi_v <= 16'h0000;
        cyc(12);
        check({gen_o, pfi_o}, 64'h0);
        check({dst, waitreq}, 64'h1);
        nrst_i <= 1'b1;
    endtask

    // Pulse function line 0 for len cycles, count cycles destination 0 is high
    task automatic pulse(input int len, input int w);
        cnt = 0;
        for (int i = 0; i < len + w + 8; i++)
        begin
            @(posedge mclk_i);
            pfi_v[0] <= (i < len);
            if (dst[0] === 1'b1)
                cnt++;
        end
    endtask

    initial
    begin
        do_reset();
        rreg(`PPR_ADDR_CTRL, 32'h0000_0000);
        rreg(`PPR_ADDR_FILT, 32'h0000_0000);
        rreg(`PPR_ADDR_PU_GEN, 32'h0000_0000);
        rreg(8'hA0, 32'h0000_0000);
        $display("reset test done");
        // General lines as outputs, then half as inputs
        wreg(`PPR_ADDR_GEN_DIR, 32'h0000_FFFF);
        wreg(`PPR_ADDR_GEN_OUT, 32'h0000_A5C3);
        cyc(2);
        check({gen_o.oe, gen_o.out}, 32'hFFFF_A5C3);
        wreg(`PPR_ADDR_GEN_DIR, 32'h0000_00FF);
        gen_en <= 16'hFF00;
        gen_v <= 16'h1234;
        cyc(6);
        rreg(`PPR_ADDR_GEN_IN, 32'h0000_12C3);
        wreg(`PPR_ADDR_GEN_IN, 32'hFFFF_FFFF);
        rreg(`PPR_ADDR_GEN_IN, 32'h0000_12C3);
        $display("general line test done");
        // Function lines as static outputs and inputs
        wreg(`PPR_ADDR_PFI_DIR, 32'h0000_00F0);
        wreg(`PPR_ADDR_PFI_OUT, 32'h0000_00A0);
        pfi_en <= 16'h000F;
        pfi_v <= 16'h0005;
        cyc(6);
        check({pfi_o.oe, pfi_o.out}, 32'h00F0_00A0);
        rreg(`PPR_ADDR_PFI_IN, 32'h0000_00A5);
        $display("function line test done");
        // Every exported source on pin 0; two clocks shown active low
        do_reset();
        pfi_en <= 16'h0000; // Pin 0 is driven by the device here, so no clash
        wreg(`PPR_ADDR_PFI_DIR, 32'h0000_0001);
        wreg(`PPR_ADDR_PFI_MODE, 32'h0000_0001);
        for (int c = 0; c < 16; c++)
        begin
            src <= ppr_src_type'((c < 14) ? (14'h0001 << c) : 14'h3FFF);
            wreg(`PPR_ADDR_OSEL_LO, 32'(c));
            cyc(3);
            check(pfi_o.out[0], (c < 14 && c != `PPR_SRC_CONV && c != `PPR_SRC_OUT_UPD));
        end
        $display("output routing test done");
        // Every destination from pin d mod 16, level mode
        do_reset();
        pfi_en <= 16'hFFFF;
        wreg(`PPR_ADDR_PFI_MODE, 32'h0000_FFFF);
        for (int d = 0; d < 24; d++)
        begin
            wreg(8'(`PPR_ADDR_DEST_BASE + 4 * d), 32'(d % 16));
            pfi_v <= 16'h0001 << (d % 16);
            cyc(6);
            check(dst[d], 1'b1);
            pfi_v <= 16'h0000;
            cyc(6);
            check(dst[d], 1'b0);
        end
        // Edge mode gives a single pulse, inverted level follows the pin low
        wreg(`PPR_ADDR_DEST_BASE, 32'h0000_0023);
        wreg(8'(`PPR_ADDR_DEST_BASE + 4), 32'h0000_0013);
        cyc(6);
        check(dst[1], 1'b1);
        pfi_v <= 16'h0008;
        cnt = 0;
        repeat (12)
        begin
            @(posedge mclk_i);
            if (dst[0] === 1'b1)
                cnt++;
        end
        check(cnt, 1);
        check(dst[1], 1'b0);
        $display("input routing test done");
        // Debounce windows for every filter code on pin 0
        do_reset();
        wreg(`PPR_ADDR_PFI_MODE, 32'h0000_FFFF);
        wreg(`PPR_ADDR_DEST_BASE, 32'h0000_0000);
        for (int k = 0; k < 4; k++)
        begin
            wreg(`PPR_ADDR_FILT, 32'(k));
            if (k > 0)
            begin
                pulse(win[k] - 1, win[k]);
                check(cnt, 0);
            end
            pulse(win[k] + 1, win[k]);
            check(cnt, win[k] + 1);
        end
        $display("filter test done");
        // Stored power-up states take effect only on apply
        do_reset();
        wreg(`PPR_ADDR_PU_GEN, 32'h0000_0006);
        wreg(`PPR_ADDR_PU_PFI, 32'h8000_0000);
        cyc(3);
        check({gen_o.oe, pfi_o.oe}, 32'h0000_0000);
        wreg(`PPR_ADDR_CTRL, 32'h0000_0004);
        cyc(3);
        check({gen_o.oe, gen_o.out, pfi_o.oe, pfi_o.out}, 64'h0003_0001_8000_8000);
        rreg(`PPR_ADDR_CTRL, 32'h0000_0000);
        $display("power-up test done");
        // Fixed-direction variant with whole-port enable
        do_reset();
        pfi_en <= 16'h00FF;
        wreg(`PPR_ADDR_PFI_OUT, 32'h0000_FF00);
        wreg(`PPR_ADDR_CTRL, 32'h0000_0001);
        cyc(3);
        check({pfi_o.oe[15:8], gen_o.oe}, 24'h00_0000);
        wreg(`PPR_ADDR_CTRL, 32'h0000_0003);
        pfi_v <= 16'h003C;
        cyc(6);
        check({pfi_o.oe[15:8], pfi_o.out[15:8]}, 16'hFFFF);
        rreg(`PPR_ADDR_GEN_IN, 32'h0000_003C);
        $display("fixed variant test done");
        finish_test();
    end
endmodule
